// [hdl/cgr_pkg.sv]
// package: register map, reset values and carriers for the clock generator config bank
package cgr_pkg;

  // byte offsets on the host port
  localparam logic [7:0] OFF_TAG_HIGH = 8'h01; // record tag bits 23:16
  localparam logic [7:0] OFF_STATUS = 8'h0c; // latched status bits
  localparam logic [7:0] OFF_FREEZE = 8'h0d; // status freeze control
  localparam logic [7:0] OFF_TAG_LO_MSB = 8'h0e; // record tag bits 15:8
  localparam logic [7:0] OFF_TAG_LO_LSB = 8'h0f; // record tag bits 7:0
  localparam logic [7:0] OFF_LOW_POWER = 8'h46; // per pair reduced power
  localparam logic [7:0] OFF_BASE_MSB = 8'h50; // base rate bits 15:8
  localparam logic [7:0] OFF_BASE_LSB = 8'h51; // base rate bits 7:0

  // values after reset
  localparam logic [7:0] RST_FREEZE = 8'h00;
  localparam logic [7:0] RST_TAG_HIGH = 8'hff;
  localparam logic [15:0] RST_TAG_LOW = 16'h0000;
  localparam logic [7:0] RST_LOW_POWER = 8'hff;
  localparam logic [15:0] RST_BASE_RATE = 16'h9c40;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // freeze control codes
  localparam logic [7:0] FREEZE_ON = 8'h01;
  localparam logic [7:0] FREEZE_OFF = 8'h00;

  // record tag limits
  localparam logic [23:0] TAG_MAX_CUSTOM = 24'h0e1780;
  localparam logic [23:0] TAG_FACTORY = 24'hff0000;

  // supported base rates in hertz
  localparam int NUM_RATES = 9;
  localparam logic [15:0] BASE_RATES [NUM_RATES] = '{
    16'h03e8, 16'h07d0, 16'h1388, 16'h186a, 16'h1f40,
    16'h2710, 16'h30d4, 16'h61a8, 16'h9c40
  };

  // one host access, same clock as the bank
  typedef struct packed {
    logic [7:0] addr; // byte offset
    logic [7:0] wdata; // write byte
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
  } cgr_host_req_t;

  // whole state of the bank
  typedef struct packed {
    logic [7:0] freeze; // freeze control as written
    logic [7:0] tag_high; // record tag 23:16
    logic [15:0] tag_low; // record tag 15:0
    logic [7:0] low_power; // reduced power per pair
    logic [15:0] base_rate; // base rate in hertz
    logic [7:0] status; // latched status bits
    logic [7:0] rdata; // read answer
    logic rvalid; // read answer strobe
    logic frozen; // freeze in force
    logic tag_ok; // record tag in legal set
    logic rate_ok; // base rate in supported set
  } cgr_state_t;

endpackage : cgr_pkg

// [hdl/cgr_range_chk.sv]
// legality checks for the record tag and the base rate
`timescale 1ns/1ns
`default_nettype none

module cgr_range_chk (
  input wire logic [23:0] tag,
  input wire logic [15:0] rate,
  output logic tag_ok,
  output logic rate_ok
);

  // tag: custom range or the factory marker only
  always_comb begin
    tag_ok = (tag <= cgr_pkg::TAG_MAX_CUSTOM) || (tag == cgr_pkg::TAG_FACTORY);
  end

  // rate: compare against the short list of supported values
  always_comb begin
    rate_ok = 1'b0;
    for (int i = 0; i < cgr_pkg::NUM_RATES; i++) begin
      if (rate == cgr_pkg::BASE_RATES[i]) begin
        rate_ok = 1'b1;
      end
    end
  end

endmodule : cgr_range_chk

`default_nettype wire

// [hdl/cgr_regs.sv]
// config register bank: status freeze, record tag, pair power, base rate
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - writing 0x01 freezes latched status updates
// - writing 0x00 resumes latched status updates
// - tag bits 15:0 sit in a byte pair
// - tag legal only up to 0x0E1780 or 0xFF0000
// - factory default reports tag 0xFF0000
// - set power bit puts pair n low power
// - cleared power bit gives full power
// - base rate field is plain hertz
// - tag bits 23:16 own byte, reset all ones
module cgr_regs #(
  parameter int NUM_PAIRS = 8 // differential pairs served
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire cgr_pkg::cgr_host_req_t host_req,
  input wire logic [7:0] status_event,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic status_frozen,
  output logic [7:0] latched_read_status,
  output logic [23:0] setup_record_tag,
  output logic setup_tag_ok,
  output logic [NUM_PAIRS-1:0] diff_output_low_power,
  output logic [15:0] synth_zero_base_rate,
  output logic base_rate_ok
);

  // refuse pair counts the byte register cannot hold
  if (NUM_PAIRS < 1 || NUM_PAIRS > 8) begin : g_bad_pairs
    $error("NUM_PAIRS must be 1 to 8");
  end

  cgr_pkg::cgr_state_t state_r; // registered state
  cgr_pkg::cgr_state_t state_nxt; // next state
  logic chk_tag_ok; // legality of next tag
  logic chk_rate_ok; // legality of next rate

  // address match, used by every register
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // read mux, unmapped offsets answer zero
  function automatic logic [7:0] read_byte(input cgr_pkg::cgr_state_t s,
                                           input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      cgr_pkg::OFF_TAG_HIGH: v = s.tag_high;
      cgr_pkg::OFF_STATUS: v = s.status;
      cgr_pkg::OFF_FREEZE: v = s.freeze;
      cgr_pkg::OFF_TAG_LO_MSB: v = s.tag_low[15:8];
      cgr_pkg::OFF_TAG_LO_LSB: v = s.tag_low[7:0];
      cgr_pkg::OFF_LOW_POWER: v = s.low_power;
      cgr_pkg::OFF_BASE_MSB: v = s.base_rate[15:8];
      cgr_pkg::OFF_BASE_LSB: v = s.base_rate[7:0];
      default: v = 8'h00;
    endcase
    read_byte = v;
  endfunction : read_byte

  // legality of the values about to be stored
  cgr_range_chk u_chk (
    .tag({state_nxt.tag_high, state_nxt.tag_low}),
    .rate(state_nxt.base_rate),
    .tag_ok(chk_tag_ok),
    .rate_ok(chk_rate_ok)
  );

  // next state: host writes, status capture, read answer
  always_comb begin
    logic wr;
    logic [7:0] clr;
    wr = host_req.wr;
    clr = 8'h00;
    state_nxt = state_r;
    // host writes, one byte per strobe
    if (wr && hit(host_req.addr, cgr_pkg::OFF_FREEZE)) begin
      state_nxt.freeze = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_TAG_HIGH)) begin
      state_nxt.tag_high = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_TAG_LO_MSB)) begin
      state_nxt.tag_low[15:8] = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_TAG_LO_LSB)) begin
      state_nxt.tag_low[7:0] = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_LOW_POWER)) begin
      state_nxt.low_power = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_BASE_MSB)) begin
      state_nxt.base_rate[15:8] = host_req.wdata;
    end
    if (wr && hit(host_req.addr, cgr_pkg::OFF_BASE_LSB)) begin
      state_nxt.base_rate[7:0] = host_req.wdata;
    end
    // status clear is write one to clear
    if (wr && hit(host_req.addr, cgr_pkg::OFF_STATUS)) begin
      clr = host_req.wdata;
    end
    // freeze follows bit 0, so 0x01 locks and 0x00 unlocks
    state_nxt.frozen = state_nxt.freeze[0];
    // capture events unless frozen; a set beats a clear in the same cycle
    for (int i = 0; i < 8; i++) begin
      if (status_event[i] && !state_r.frozen) begin
        state_nxt.status[i] = 1'b1;
      end else if (clr[i]) begin
        state_nxt.status[i] = 1'b0;
      end
    end
    // read answer one cycle after the strobe, old contents
    state_nxt.rvalid = host_req.rd;
    state_nxt.rdata = host_req.rd ? read_byte(state_r, host_req.addr) : 8'h00;
    // legality flags travel with the values they describe
    state_nxt.tag_ok = chk_tag_ok;
    state_nxt.rate_ok = chk_rate_ok;
  end

  // one register stage; reset beats the clock enable
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r.freeze <= cgr_pkg::RST_FREEZE;
      state_r.tag_high <= cgr_pkg::RST_TAG_HIGH;
      state_r.tag_low <= cgr_pkg::RST_TAG_LOW;
      state_r.low_power <= cgr_pkg::RST_LOW_POWER;
      state_r.base_rate <= cgr_pkg::RST_BASE_RATE;
      state_r.status <= cgr_pkg::RST_STATUS;
      state_r.rdata <= 8'h00;
      state_r.rvalid <= 1'b0;
      state_r.frozen <= 1'b0;
      state_r.tag_ok <= 1'b1; // factory marker is legal
      state_r.rate_ok <= 1'b1; // reset rate is supported
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign host_rdata = state_r.rdata;
  assign host_rvalid = state_r.rvalid;
  assign status_frozen = state_r.frozen;
  assign latched_read_status = state_r.status;
  assign setup_record_tag = {state_r.tag_high, state_r.tag_low};
  assign setup_tag_ok = state_r.tag_ok;
  // high bit means reduced power, low bit full power
  assign diff_output_low_power = state_r.low_power[NUM_PAIRS-1:0];
  assign synth_zero_base_rate = state_r.base_rate;
  assign base_rate_ok = state_r.rate_ok;

  // checks against the state register
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_freeze_on_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_FREEZE
      && host_req.wdata == cgr_pkg::FREEZE_ON |=> status_frozen)
    else $error("freeze not set after 0x01 write");

  a_freeze_off_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_FREEZE
      && host_req.wdata == cgr_pkg::FREEZE_OFF |=> !status_frozen)
    else $error("freeze not released after 0x00 write");

  a_frozen_status_hold: assert property (
    status_frozen && !(host_req.wr && host_req.addr == cgr_pkg::OFF_STATUS)
      |=> $stable(latched_read_status))
    else $error("latched status changed while frozen");

  a_event_capture: assert property (
    clk_en && !status_frozen && status_event[0] |=> latched_read_status[0])
    else $error("event lost while unfrozen");

  a_tag_low_read: assert property (
    clk_en && host_req.rd && host_req.addr == cgr_pkg::OFF_TAG_LO_LSB
      |=> host_rvalid && host_rdata == $past(setup_record_tag[7:0]))
    else $error("tag low byte read wrong");

  a_tag_legal_flag: assert property (
    setup_tag_ok == (setup_record_tag <= cgr_pkg::TAG_MAX_CUSTOM
      || setup_record_tag == cgr_pkg::TAG_FACTORY))
    else $error("tag legality flag wrong");

  a_tag_after_reset: assert property (
    $past(reset) |-> setup_record_tag == cgr_pkg::TAG_FACTORY)
    else $error("tag not factory marker after reset");

  a_power_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_LOW_POWER
      |=> diff_output_low_power == $past(host_req.wdata[NUM_PAIRS-1:0]))
    else $error("pair power bits not updated");

  a_base_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_BASE_MSB
      |=> synth_zero_base_rate[15:8] == $past(host_req.wdata))
    else $error("base rate high byte not updated");

  a_freeze_readback: assert property (
    clk_en && host_req.rd && host_req.addr == cgr_pkg::OFF_FREEZE
      |=> host_rdata == $past(state_r.freeze))
    else $error("freeze readback wrong");

  // each byte lands at the edge that takes it
  a_tag_high_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_TAG_HIGH
      |=> setup_record_tag[23:16] == $past(host_req.wdata))
    else $error("tag high byte not updated");

  a_tag_msb_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_TAG_LO_MSB
      |=> setup_record_tag[15:8] == $past(host_req.wdata))
    else $error("tag bits 15:8 not updated");

  a_tag_lsb_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_TAG_LO_LSB
      |=> setup_record_tag[7:0] == $past(host_req.wdata))
    else $error("tag bits 7:0 not updated");

  a_base_low_write: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_BASE_LSB
      |=> synth_zero_base_rate[7:0] == $past(host_req.wdata))
    else $error("base rate low byte not updated");

  a_power_full: assert property (
    clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_LOW_POWER
      && host_req.wdata == 8'h00 |=> diff_output_low_power == '0)
    else $error("pairs not at full power after clear");

  // registers hold between writes to their own offsets
  a_tag_hold: assert property (
    !(clk_en && host_req.wr && (host_req.addr == cgr_pkg::OFF_TAG_HIGH
      || host_req.addr == cgr_pkg::OFF_TAG_LO_MSB
      || host_req.addr == cgr_pkg::OFF_TAG_LO_LSB)) |=> $stable(setup_record_tag))
    else $error("record tag changed without a write");

  a_power_hold: assert property (
    !(clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_LOW_POWER)
      |=> $stable(diff_output_low_power))
    else $error("pair power bits changed without a write");

  a_base_hold: assert property (
    !(clk_en && host_req.wr && (host_req.addr == cgr_pkg::OFF_BASE_MSB
      || host_req.addr == cgr_pkg::OFF_BASE_LSB)) |=> $stable(synth_zero_base_rate))
    else $error("base rate changed without a write");

  a_freeze_hold: assert property (
    !(clk_en && host_req.wr && host_req.addr == cgr_pkg::OFF_FREEZE)
      |=> $stable(status_frozen))
    else $error("freeze changed without a write");

  // status clear and capture corners
  a_clear_while_frozen: assert property (
    clk_en && status_frozen && host_req.wr && host_req.addr == cgr_pkg::OFF_STATUS
      && host_req.wdata[0] |=> !latched_read_status[0])
    else $error("clear ignored while frozen");

  a_set_beats_clear: assert property (
    clk_en && !status_frozen && status_event[0] && host_req.wr
      && host_req.addr == cgr_pkg::OFF_STATUS && host_req.wdata[0] |=> latched_read_status[0])
    else $error("clear beat a same cycle event");

  a_event_dropped: assert property (
    clk_en && status_frozen && status_event[0] && !latched_read_status[0]
      |=> !latched_read_status[0])
    else $error("event latched while frozen");

  // read answer only follows a read strobe
  a_rvalid_pulse: assert property (
    clk_en && !host_req.rd |=> !host_rvalid && host_rdata == 8'h00)
    else $error("read answer without a read");

  // values right after reset
  a_power_after_reset: assert property (
    $past(reset) |-> diff_output_low_power == cgr_pkg::RST_LOW_POWER[NUM_PAIRS-1:0])
    else $error("pair power bits wrong after reset");

  a_base_after_reset: assert property (
    $past(reset) |-> synth_zero_base_rate == cgr_pkg::RST_BASE_RATE)
    else $error("base rate wrong after reset");

  a_freeze_after_reset: assert property (
    $past(reset) |-> !status_frozen)
    else $error("freeze in force after reset");

  c_event_while_frozen: cover property (status_frozen && status_event != 8'h00);
  c_freeze_cycle: cover property (status_frozen ##[1:20] !status_frozen);
  c_bad_rate: cover property (!base_rate_ok);
  c_custom_tag: cover property (setup_tag_ok && setup_record_tag != cgr_pkg::TAG_FACTORY);
  c_set_and_clear: cover property (status_event[0] && host_req.wr
    && host_req.addr == cgr_pkg::OFF_STATUS && host_req.wdata[0]);

endmodule : cgr_regs

`default_nettype wire

// [verif/cgr_host_model.sv]
// host model: byte writes and reads on the register port
`timescale 1ns/1ns
`default_nettype none
module cgr_host_model (
  input wire logic clk,
  output var cgr_pkg::cgr_host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial host_req = '0; // idle, no strobe
  // one-cycle write strobe; released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    host_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask : wr
  // read strobe; the answer stands for one cycle after the taking edge, sampled once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    host_req <= '{addr: ~a, wdata: 8'h5a, wr: 1'b0, rd: 1'b0};
    #1;
    ok = (host_rvalid === 1'b1);
    d = host_rdata;
  endtask : rd
endmodule : cgr_host_model
`default_nettype wire

// [verif/clock_gen_config_regs_tb.sv]
// testbench: register bank driven through the host model
`timescale 1ns/1ns
`default_nettype none
module clock_gen_config_regs_tb;
  logic clk = 1'b0; // 20 mhz
  logic reset = 1'b1; // held 16 cycles
  logic clk_en = 1'b1; // dropped once to show nothing is taken, and once more during the mid-run reset
  logic [7:0] status_event = 8'h00; // internal events
  cgr_pkg::cgr_host_req_t host_req;
  logic [7:0] host_rdata;
  logic host_rvalid;
  logic status_frozen;
  logic [7:0] latched_read_status;
  logic [23:0] setup_record_tag;
  logic setup_tag_ok;
  logic [7:0] diff_output_low_power;
  logic [15:0] synth_zero_base_rate;
  logic base_rate_ok;
  int err_total = 0;
  int n_checks = 0;
  always #25 clk = ~clk; // half period
  cgr_regs #(.NUM_PAIRS(8)) u_cgr_regs (.clk(clk), .reset(reset), .clk_en(clk_en),
    .host_req(host_req), .status_event(status_event), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .status_frozen(status_frozen),
    .latched_read_status(latched_read_status), .setup_record_tag(setup_record_tag),
    .setup_tag_ok(setup_tag_ok), .diff_output_low_power(diff_output_low_power),
    .synth_zero_base_rate(synth_zero_base_rate), .base_rate_ok(base_rate_ok));
  cgr_host_model u_cgr_host_model (.clk(clk), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  // compare one value, report at once on mismatch
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // read a byte and compare answer strobe and data
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_cgr_host_model.rd(a, d, ok);
    chk("rvalid", {23'h0, ok}, 24'h1);
    chk("rdata", {16'h0, d}, {16'h0, exp});
  endtask : rdc
  // one-cycle pulse of status events, then one settle cycle
  task automatic ev(input logic [7:0] v);
    @(posedge clk);
    status_event <= v;
    @(posedge clk);
    status_event <= 8'h00;
    @(posedge clk);
    #1;
  endtask : ev
  // tag write in three bytes, high byte first
  task automatic wtag(input logic [23:0] t);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_HIGH, t[23:16]);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_LO_MSB, t[15:8]);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_LO_LSB, t[7:0]);
  endtask : wtag
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // watchdog: tests need well under 2000 cycles
  initial begin
    #(5000 * 50);
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("tag reset", setup_record_tag, 24'hff0000);
    chk("tag ok reset", {23'h0, setup_tag_ok}, 24'h1);
    chk("power reset", {16'h0, diff_output_low_power}, 24'h0000ff);
    chk("rate reset", {8'h0, synth_zero_base_rate}, 24'h009c40);
    rdc(cgr_pkg::OFF_TAG_HIGH, 8'hff);
    rdc(cgr_pkg::OFF_TAG_LO_MSB, 8'h00);
    rdc(cgr_pkg::OFF_FREEZE, 8'h00);
    rdc(cgr_pkg::OFF_BASE_LSB, 8'h40);
    rdc(8'h30, 8'h00); // unmapped place answers zero
    // tag pair layout and legal set boundaries
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_LO_MSB, 8'h12);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_LO_LSB, 8'h34);
    chk("tag low", setup_record_tag, 24'hff1234);
    chk("tag ok", {23'h0, setup_tag_ok}, 24'h0);
    rdc(cgr_pkg::OFF_TAG_LO_LSB, 8'h34);
    wtag(24'h0e1780);
    chk("tag ok", {23'h0, setup_tag_ok}, 24'h1);
    chk("tag high", setup_record_tag, 24'h0e1780);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_LO_LSB, 8'h81);
    chk("tag ok", {23'h0, setup_tag_ok}, 24'h0);
    wtag(24'hff0000);
    chk("tag ok", {23'h0, setup_tag_ok}, 24'h1);
    // each pair alone in reduced power, then all full power
    for (int n = 0; n < 8; n++) begin
      u_cgr_host_model.wr(cgr_pkg::OFF_LOW_POWER, 8'h01 << n);
      chk("power", {16'h0, diff_output_low_power}, {16'h0, 8'h01 << n});
    end
    u_cgr_host_model.wr(cgr_pkg::OFF_LOW_POWER, 8'h00);
    chk("power", {16'h0, diff_output_low_power}, 24'h0);
    // write held off while the clock enable is low
    @(posedge clk);
    clk_en <= 1'b0;
    u_cgr_host_model.wr(cgr_pkg::OFF_LOW_POWER, 8'ha5);
    @(posedge clk);
    clk_en <= 1'b1;
    #1;
    chk("power", {16'h0, diff_output_low_power}, 24'h0);
    // every supported base rate, msb then lsb
    for (int i = 0; i < cgr_pkg::NUM_RATES; i++) begin
      u_cgr_host_model.wr(cgr_pkg::OFF_BASE_MSB, cgr_pkg::BASE_RATES[i][15:8]);
      u_cgr_host_model.wr(cgr_pkg::OFF_BASE_LSB, cgr_pkg::BASE_RATES[i][7:0]);
      chk("rate", {8'h0, synth_zero_base_rate}, {8'h0, cgr_pkg::BASE_RATES[i]});
      chk("rate ok", {23'h0, base_rate_ok}, 24'h1);
    end
    u_cgr_host_model.wr(cgr_pkg::OFF_BASE_LSB, 8'h41);
    chk("rate", {8'h0, synth_zero_base_rate}, 24'h009c41);
    chk("rate ok", {23'h0, base_rate_ok}, 24'h0);
    // freeze drops events, release lets them latch again
    u_cgr_host_model.wr(cgr_pkg::OFF_FREEZE, 8'h01);
    chk("frozen", {23'h0, status_frozen}, 24'h1);
    rdc(cgr_pkg::OFF_FREEZE, 8'h01);
    ev(8'h0f);
    chk("status", {16'h0, latched_read_status}, 24'h0);
    u_cgr_host_model.wr(cgr_pkg::OFF_FREEZE, 8'h00);
    chk("frozen", {23'h0, status_frozen}, 24'h0);
    ev(8'ha1);
    chk("status", {16'h0, latched_read_status}, 24'h0000a1);
    rdc(cgr_pkg::OFF_STATUS, 8'ha1);
    // write one to clear, then an event beating a clear of the same bit
    u_cgr_host_model.wr(cgr_pkg::OFF_STATUS, 8'h81);
    chk("status", {16'h0, latched_read_status}, 24'h000020);
    fork
      u_cgr_host_model.wr(cgr_pkg::OFF_STATUS, 8'h21);
      ev(8'h01);
    join
    chk("status", {16'h0, latched_read_status}, 24'h000001);
    rdc(cgr_pkg::OFF_FREEZE, 8'h00);
    // clear still acts while frozen
    u_cgr_host_model.wr(cgr_pkg::OFF_FREEZE, 8'h01);
    u_cgr_host_model.wr(cgr_pkg::OFF_STATUS, 8'h01);
    chk("status", {16'h0, latched_read_status}, 24'h0);
    u_cgr_host_model.wr(cgr_pkg::OFF_TAG_HIGH, 8'h01);
    chk("tag high", setup_record_tag, 24'h010000);
    // mid-run reset with the enable low: reset still wins
    @(posedge clk);
    reset <= 1'b1;
    clk_en <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk("tag reset", setup_record_tag, 24'hff0000);
    chk("frozen reset", {23'h0, status_frozen}, 24'h0);
    chk("status reset", {16'h0, latched_read_status}, 24'h0);
    chk("power reset", {16'h0, diff_output_low_power}, 24'h0000ff);
    chk("rate reset", {8'h0, synth_zero_base_rate}, 24'h009c40);
    rdc(cgr_pkg::OFF_FREEZE, 8'h00);
    wrap_up();
  end
endmodule : clock_gen_config_regs_tb
`default_nettype wire
